// [hw/dac_control_registers.sv]
// Special function registers and output latch of the voltage-output converter
// Function
// - 12-bit output updates on low byte write
// - Control bit 4 selects output pin
// - Bit 3: low byte to MSBs, LSBs zero
// - Control bit 2 selects output range
// - Control bit 1 low clears data bytes
// - Control bit 0 low powers converter down
// - Control bits 7 to 5 have no effect
// - Bit 3 low: code right-justified, high nibble in high byte
module dac_control_registers
    import dac_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic [11:0] converter_code,
    output logic output_range_select,
    output logic output_pin_select,
    output logic converter_power_down
);
    logic [7:0] control_ff, nxt_control;
    logic [7:0] data_low_ff, nxt_data_low;
    logic [7:0] data_high_ff, nxt_data_high;
    logic [11:0] code_ff, nxt_code;
    logic range_ff, nxt_range;
    logic pin_ff, nxt_pin;
    logic pd_ff, nxt_pd;
    logic [7:0] rdata_ff, nxt_rdata;
    logic wr_low, wr_high, wr_ctrl;
    logic [7:0] ctrl_eff;
    logic [11:0] new_code;
    logic clear_active;

    // Control fields must fill bits 4..0 exactly; 7..5 stay reserved
    localparam int USED_FIELDS = (1 << BIT_ENABLE) | (1 << BIT_CLEAR_N) | (1 << BIT_RANGE)
        | (1 << BIT_EIGHT) | (1 << BIT_PIN);

    if (CODE_W != 12) begin : g_code_width
        $error("converter code must be twelve bits wide");
    end
    if (USED_FIELDS != 32'h1F) begin : g_field_layout
        $error("control fields overlap or leave bits 4..0");
    end

    // A control write steers data and code logic on the same edge
    always_comb begin
        wr_low = sfr_wr && (sfr_addr == ADDR_DATA_LOW);
        wr_high = sfr_wr && (sfr_addr == ADDR_DATA_HIGH);
        wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONTROL);
        ctrl_eff = wr_ctrl ? sfr_wdata : control_ff;
        clear_active = !ctrl_eff[BIT_CLEAR_N];
    end

    always_comb begin
        nxt_control = ctrl_eff;
    end

    // Reserved bits 7..5 are stored for readback and steer nothing
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            control_ff <= RESET_BYTE;
        end else begin
            control_ff <= nxt_control;
        end
    end

    always_comb begin
        nxt_data_low = wr_low ? sfr_wdata : data_low_ff;
        nxt_data_high = wr_high ? sfr_wdata : data_high_ff;
        // Clear wins over a data write in the same cycle
        if (clear_active) begin
            nxt_data_low = RESET_BYTE;
            nxt_data_high = RESET_BYTE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            data_low_ff <= RESET_BYTE;
            data_high_ff <= RESET_BYTE;
        end else begin
            data_low_ff <= nxt_data_low;
            data_high_ff <= nxt_data_high;
        end
    end

    // Clear empties the data bytes; the latched output holds until a low write, which then latches the cleared low byte
    always_comb begin
        if (ctrl_eff[BIT_EIGHT]) begin
            new_code = {nxt_data_low, 4'h0};
        end else begin
            new_code = {data_high_ff[3:0] & HIGH_NIBBLE_MASK, nxt_data_low};
        end
        // High byte is only staged, so a half-written code never shows
        nxt_code = wr_low ? new_code : code_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            code_ff <= CODE_RESET;
        end else begin
            code_ff <= nxt_code;
        end
    end

    always_comb begin
        nxt_range = ctrl_eff[BIT_RANGE];
        nxt_pin = ctrl_eff[BIT_PIN];
        nxt_pd = !ctrl_eff[BIT_ENABLE];
    end

    // All clear in reset; power-down rises on the first edge after release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            range_ff <= 1'b0;
            pin_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else begin
            range_ff <= nxt_range;
            pin_ff <= nxt_pin;
            pd_ff <= nxt_pd;
        end
    end

    // Reads have no side effect; the last value stands until the next read
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_DATA_LOW: nxt_rdata = data_low_ff;
                ADDR_DATA_HIGH: nxt_rdata = data_high_ff;
                ADDR_CONTROL: nxt_rdata = control_ff;
                default: nxt_rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_ff <= RESET_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign converter_code = code_ff;
    assign output_range_select = range_ff;
    assign output_pin_select = pin_ff;
    assign converter_power_down = pd_ff;

    a_low_write_update: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_low && !ctrl_eff[BIT_EIGHT] && ctrl_eff[BIT_CLEAR_N]
        |=> converter_code == {$past(data_high_ff[3:0]), $past(sfr_wdata)})
        else $error("code not latched on low write");
    a_high_no_update: assert property (@(posedge sys_clk) disable iff (!resetn)
        !wr_low |=> $stable(converter_code))
        else $error("code changed without low write");
    a_eight_bit_code: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_low && ctrl_eff[BIT_EIGHT] && ctrl_eff[BIT_CLEAR_N]
        |=> converter_code == {$past(sfr_wdata), 4'h0})
        else $error("eight bit code wrong");
    a_pin_select: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_ctrl |=> output_pin_select == $past(sfr_wdata[BIT_PIN]))
        else $error("pin select wrong");
    a_range_select: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_ctrl |=> output_range_select == $past(sfr_wdata[BIT_RANGE]))
        else $error("range select wrong");
    a_clear_data: assert property (@(posedge sys_clk) disable iff (!resetn)
        !control_ff[BIT_CLEAR_N] && !wr_ctrl |=> data_low_ff == 8'h00 && data_high_ff == 8'h00)
        else $error("data not cleared");
    a_power_down: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_ctrl |=> converter_power_down == !$past(sfr_wdata[BIT_ENABLE]))
        else $error("power down wrong");
    a_reserved_inert: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_ctrl && !wr_low ##1 1'b1 |-> $stable(converter_code))
        else $error("reserved bits affected code");
    a_reset_outputs: assert property (@(posedge sys_clk)
        !resetn |=> converter_code == 12'h000 && !converter_power_down && !output_pin_select
            && !output_range_select)
        else $error("outputs not reset");

    a_clear_same_edge: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_ctrl && !sfr_wdata[BIT_CLEAR_N] |=> data_low_ff == 8'h00 && data_high_ff == 8'h00)
        else $error("data not cleared on control write");

    a_clear_low_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_low && ctrl_eff[BIT_EIGHT] && !ctrl_eff[BIT_CLEAR_N] |=> converter_code == 12'h000)
        else $error("cleared eight bit write not zero");

    a_twelve_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_low && !ctrl_eff[BIT_EIGHT] && !ctrl_eff[BIT_CLEAR_N] |=> converter_code[7:0] == 8'h00)
        else $error("cleared twelve bit write not zero");

    a_eight_lsb_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_low && ctrl_eff[BIT_EIGHT] |=> converter_code[3:0] == 4'h0)
        else $error("eight bit low nibble not zero");

    a_data_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        !wr_low && !wr_high && !wr_ctrl && control_ff[BIT_CLEAR_N]
        |=> $stable(data_low_ff) && $stable(data_high_ff))
        else $error("data bytes moved without a write");

    a_controls_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        !wr_ctrl && $past(resetn) |=> $stable(converter_power_down)
            && $stable(output_range_select) && $stable(output_pin_select))
        else $error("analogue controls moved without control write");

    a_read_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");

    a_low_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
        sfr_rd && sfr_addr == ADDR_DATA_LOW |=> sfr_rdata == $past(data_low_ff))
        else $error("low byte readback wrong");
endmodule

// [shared/dac_ctrl_pkg.sv]
// Constants for the converter control register block
package dac_ctrl_pkg;
    localparam logic [7:0] ADDR_DATA_LOW = 8'hFB;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hFC;
    localparam logic [7:0] ADDR_CONTROL = 8'hFD;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_CLEAR_N = 1;
    localparam int BIT_RANGE = 2;
    localparam int BIT_EIGHT = 3;
    localparam int BIT_PIN = 4;
    localparam int CODE_W = 12;
    localparam logic [3:0] HIGH_NIBBLE_MASK = 4'hF;
    localparam logic [11:0] CODE_RESET = 12'h000;
endpackage

// [bench/sfr_core.sv]
// Core model issuing one-cycle register strobes
module sfr_core (
    input wire logic sys_clk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge sys_clk);
        #1;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
        @(posedge sys_clk);
        #1;
        {sfr_wr, sfr_rd} = '0;
    endtask
endmodule

// [bench/tb.sv]
// Scoreboard bench for the converter control registers
module tb;
    import dac_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, resetn = 0, sfr_wr, sfr_rd, rd_q = 0, rng, pin, pd;
    logic [7:0] sfr_addr, sfr_wdata, rdata, lo = 0, hi = 0, ctl = 0;
    logic [11:0] code, m_code = 0;
    logic [22:0] exp_q[$];
    int err_total = 0, checked = 0, seed = 63;
    always #5 sys_clk = ~sys_clk;
    sfr_core core (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
    dac_control_registers DUT (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata),
        .converter_code(code), .output_range_select(rng), .output_pin_select(pin),
        .converter_power_down(pd));
    task automatic check(input logic [22:0] seen, input logic [22:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.cyc(a, d, 1);
        if (a == ADDR_CONTROL) ctl = d;
        if (a == ADDR_DATA_HIGH) hi = d;
        if (a == ADDR_DATA_LOW) lo = d;
        if (!ctl[BIT_CLEAR_N]) {hi, lo} = '0;
        if (a == ADDR_DATA_LOW) m_code = ctl[BIT_EIGHT] ? {lo, 4'h0} : {hi[3:0], lo};
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] v;
        v = a == ADDR_CONTROL ? ctl : a == ADDR_DATA_HIGH ? hi : a == ADDR_DATA_LOW ? lo : 8'h00;
        exp_q.push_back({v, m_code, ctl[BIT_RANGE], ctl[BIT_PIN], !ctl[BIT_ENABLE]});
        core.cyc(a, 8'h00, 0);
    endtask
    // Read data lands one edge after the strobe; look mid-cycle, clear of the edge
    always @(posedge sys_clk) rd_q <= sfr_rd;
    always @(negedge sys_clk) begin
        if (rd_q) check({rdata, code, rng, pin, pd}, exp_q.pop_front());
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 check(23'({code, rng, pin, pd}), 23'h0);
        resetn = 1;
        for (int i = 0; i < 4; i++) rd(ADDR_DATA_LOW + 8'(i));
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            wr(ADDR_CONTROL, 8'($random(seed)));
            wr(ADDR_DATA_HIGH, 8'($random(seed)));
            rd(ADDR_CONTROL);
            wr(ADDR_DATA_LOW, 8'($random(seed)));
            rd(ADDR_DATA_LOW + 8'(i % 4));
        end
        $display("random test done");
        @(posedge sys_clk);
        #1 resetn = 0;
        repeat (4) @(posedge sys_clk);
        #1 check(23'({code, rng, pin, pd}), 23'h0);
        resetn = 1;
        {ctl, hi, lo, m_code} = '0;
        for (int i = 0; i < 4; i++) rd(ADDR_DATA_LOW + 8'(i));
        $display("mid-run reset test done");
        repeat (3) @(posedge sys_clk);
        check(23'(exp_q.size()), 23'h0);
        wrap_up();
    end
endmodule
